// ---- hw/imuio_pkg.sv ----
// shared constants and types for the sample and i/o control block
package imuio_pkg;
	// clock rate and printed time figures
	localparam int CLK_KHZ = 40000;
	localparam real TB_FAST_MS = 0.61035;
	localparam real TB_SLOW_MS = 18.921;
	localparam real DR_MIN_US = 100.0;
	localparam real DR_MAX_US = 200.0;
	localparam real DR_PULSE_US = 150.0;
	localparam real SLEEP_LSB_S = 0.5;
	localparam int TB_FAST_CYC = int'(TB_FAST_MS * real'(CLK_KHZ));
	localparam int TB_SLOW_CYC = int'(TB_SLOW_MS * real'(CLK_KHZ));
	localparam int DR_MIN_CYC = int'($ceil(DR_MIN_US * real'(CLK_KHZ) / 1000.0));
	localparam int DR_MAX_CYC = int'($floor(DR_MAX_US * real'(CLK_KHZ) / 1000.0));
	localparam int DR_PULSE_CYC = int'(DR_PULSE_US * real'(CLK_KHZ) / 1000.0);
	localparam int SLEEP_LSB_CYC = int'(SLEEP_LSB_S * 1000.0 * real'(CLK_KHZ));
	localparam int MEMTEST_CYC = 600;
	localparam int SELFTEST_CYC = 800;
	// register addresses (byte address of the low byte)
	localparam logic [6:0] ADDR_OUT = 7'h04;
	localparam logic [6:0] ADDR_PIN_IO = 7'h32;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_SMPL = 7'h36;
	localparam logic [6:0] ADDR_RANGE = 7'h38;
	localparam logic [6:0] ADDR_SLEEP = 7'h3a;
	// reset values and writable bits
	localparam logic [15:0] SMPL_RST = 16'h0001;
	localparam logic [15:0] RANGE_RST = 16'h0402;
	localparam logic [15:0] PIN_IO_RST = 16'h0000;
	localparam logic [15:0] MISC_RST = 16'h0006;
	localparam logic [15:0] SLEEP_RST = 16'h0000;
	localparam logic [15:0] SMPL_MASK = 16'h00ff;
	localparam logic [15:0] SLEEP_MASK = 16'h01ff;
	localparam logic [15:0] RANGE_MASK = 16'h0707;
	localparam logic [15:0] PIN_IO_MASK = 16'h0f0f;
	localparam logic [15:0] MISC_MASK = 16'h0fc7;
	// field positions
	localparam int SMPL_TB_BIT = 7;
	localparam int SLEEP_INDEF_BIT = 8;
	localparam int MISC_MEMTEST_BIT = 11;
	localparam int MISC_SELFTEST_BIT = 10;
	localparam int MISC_STIM_NEG_BIT = 9;
	localparam int MISC_STIM_POS_BIT = 8;
	localparam int MISC_BIAS_BIT = 7;
	localparam int MISC_ALIGN_BIT = 6;
	localparam int MISC_DR_EN_BIT = 2;
	localparam int MISC_DR_POL_BIT = 1;
	localparam int MISC_DR_SEL_BIT = 0;
	localparam int OUT_ND_BIT = 15;
	localparam logic [7:0] LOW_POWER_MIN = 8'h0a;
	localparam logic [2:0] RANGE_WIDE = 3'h4;
	localparam logic [2:0] RANGE_MID = 3'h2;
	localparam logic [2:0] RANGE_NARROW = 3'h1;
	localparam logic [2:0] TAP_MIN_MID = 3'h2;
	localparam logic [2:0] TAP_MIN_NARROW = 3'h4;

	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} imuio_frame_t;

	typedef struct packed {
		logic [3:0] own;
		logic [3:0] level;
	} imuio_drive_t;

	typedef enum logic [1:0] {SLP_AWAKE, SLP_TIMED, SLP_DORMANT} imuio_sleep_t;
endpackage

// ---- hw/imuio_top.sv ----
// sample period, sleep, filter, range and i/o line control
module imuio_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q, s2_q, s3_q, acc_q, acc_d;
	always_comb begin
		acc_d = acc_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				acc_d[i] = s3_q[i];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			acc_q <= INIT;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			acc_q <= acc_d;
		end
	end
	assign q = acc_q;
endmodule

module imuio_avg #(
	parameter int W = 14,
	parameter int LOGMAX = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] m,
	input wire logic in_vld,
	input wire logic signed [W-1:0] din,
	output logic signed [W-1:0] dout,
	output logic out_vld
);
	logic signed [W-1:0] hist [2**LOGMAX];
	logic [LOGMAX-1:0] ptr_q, ptr_d;
	logic [LOGMAX:0] fill_q, fill_d, taps;
	logic signed [W+LOGMAX-1:0] sum_q, sum_d, old;
	logic signed [W-1:0] dout_q, dout_d;
	logic [2:0] m_q;
	logic vld_q, vld_d;
	always_comb begin
		taps = (LOGMAX+1)'(1) << m;
		old = (fill_q == taps) ? (W+LOGMAX)'(hist[ptr_q]) : '0;
		sum_d = sum_q;
		ptr_d = ptr_q;
		fill_d = fill_q;
		dout_d = dout_q;
		vld_d = 1'b0;
		if (m != m_q) begin
			sum_d = '0;
			ptr_d = '0;
			fill_d = '0;
		end else if (in_vld) begin
			sum_d = sum_q + (W+LOGMAX)'(din) - old;
			ptr_d = ({1'b0, ptr_q} + 1'b1 == taps) ? '0 : ptr_q + 1'b1;
			fill_d = (fill_q == taps) ? fill_q : fill_q + 1'b1;
			dout_d = W'(sum_d >>> m);
			vld_d = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			sum_q <= '0;
			ptr_q <= '0;
			fill_q <= '0;
			dout_q <= '0;
			vld_q <= 1'b0;
			m_q <= '0;
		end else begin
			sum_q <= sum_d;
			ptr_q <= ptr_d;
			fill_q <= fill_d;
			dout_q <= dout_d;
			vld_q <= vld_d;
			m_q <= m;
		end
	end
	always_ff @(posedge clk) begin
		if (in_vld && m == m_q) begin
			hist[ptr_q] <= din;
		end
	end
	assign dout = dout_q;
	assign out_vld = vld_q;
endmodule

module imuio_top #(
	parameter int TB_FAST = imuio_pkg::TB_FAST_CYC,
	parameter int TB_SLOW = imuio_pkg::TB_SLOW_CYC,
	parameter int DR_PULSE = imuio_pkg::DR_PULSE_CYC,
	parameter int SLEEP_LSB = imuio_pkg::SLEEP_LSB_CYC,
	parameter int DW = 14
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire imuio_pkg::imuio_drive_t alarm_drive,
	input wire logic signed [DW-1:0] sensor_in,
	output logic sample_tick,
	output logic low_power,
	output logic asleep,
	output logic [2:0] gyro_range,
	output logic self_test_run,
	output logic mem_test_run,
	output logic stim_neg,
	output logic stim_pos,
	output logic bias_comp_en,
	output logic origin_align_en
);
	import imuio_pkg::*;

	// link side: shift in 16 bits, hold the frame until the sixteenth bit of the next frame
	logic [4:0] bit_cnt_q, bit_cnt_d;
	logic [15:0] sh_q, sh_d, frm_q, frm_d;
	logic miso_q, miso_d, miso_oe_q;
	logic [15:0] rd_word_q, rd_word_d;
	always_comb begin
		bit_cnt_d = (bit_cnt_q == 5'h10) ? bit_cnt_q : bit_cnt_q + 5'h01;
		sh_d = {sh_q[14:0], spi_mosi};
		frm_d = (bit_cnt_q == 5'h0f) ? sh_d : frm_q;
		miso_d = bit_cnt_q[4] ? 1'b0 : rd_word_q[4'(5'h0f - bit_cnt_q)];
	end
	always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			bit_cnt_q <= '0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
		end
	end
	always_ff @(posedge spi_sclk) begin
		sh_q <= sh_d;
		frm_q <= frm_d;
	end
	// read word is only changed by mclk between frames, so it is static here
	always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			miso_q <= miso_d;
			miso_oe_q <= 1'b1;
		end
	end
	assign spi_miso = miso_q;
	assign spi_miso_oe = miso_oe_q;

	// pin and frame-done crossing
	logic [5:0] sync_q;
	logic cs_n_s, done_s, done_prev_q, cs_prev_q;
	logic [3:0] io_s;
	imuio_sync3 #(.W(6), .INIT(6'h10)) u_sync (
		.clk(mclk),
		.rst(sys_rst),
		.d({bit_cnt_q[4], spi_cs_n, io_in}),
		.q(sync_q)
	);
	assign done_s = sync_q[5];
	assign cs_n_s = sync_q[4];
	assign io_s = sync_q[3:0];
	logic frame_evt, cs_fall, ln4_prev_q, ln4_rise;
	assign frame_evt = done_s & ~done_prev_q;
	assign cs_fall = cs_prev_q & ~cs_n_s;
	assign ln4_rise = io_s[3] & ~ln4_prev_q;
	imuio_frame_t fr;
	assign fr = imuio_frame_t'(frm_q);

	// registers, sleep, self-clearing tests, new-data flag
	logic [15:0] smpl_q, smpl_d, sleep_q, sleep_d, range_q, range_d;
	logic [15:0] pin_q, pin_d, misc_q, misc_d;
	imuio_sleep_t slp_q, slp_d;
	logic [24:0] half_cnt_q, half_cnt_d;
	logic [7:0] naps_q, naps_d;
	logic [11:0] mem_cnt_q, mem_cnt_d, st_cnt_q, st_cnt_d;
	logic nd_q, nd_d, out_vld;
	logic signed [DW-1:0] out_q, out_d, filt_out;
	logic [3:0] lvl;
	logic [15:0] wv;
	logic [2:0] rsel;
	logic [15:0] misc_base;

	function automatic logic [2:0] tap_floor(input logic [2:0] r);
		tap_floor = (r == RANGE_NARROW) ? TAP_MIN_NARROW :
			(r == RANGE_MID) ? TAP_MIN_MID : 3'h0;
	endfunction
	function automatic logic [15:0] put(input logic [15:0] old,
		input logic hi, input logic [7:0] b, input logic [15:0] mask);
		put = (hi ? {b, old[7:0]} : {old[15:8], b}) & mask;
	endfunction

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lvl[i] = io_oe[i] ? pin_q[8+i] : io_s[i];
		end
		smpl_d = smpl_q;
		sleep_d = sleep_q;
		range_d = range_q;
		pin_d = pin_q;
		misc_d = misc_q;
		slp_d = slp_q;
		half_cnt_d = half_cnt_q;
		naps_d = naps_q;
		rd_word_d = rd_word_q;
		out_d = out_q;
		wv = '0;
		rsel = '0;
		mem_cnt_d = (mem_cnt_q != 12'h000) ? mem_cnt_q - 12'h001 : mem_cnt_q;
		st_cnt_d = (st_cnt_q != 12'h000) ? st_cnt_q - 12'h001 : st_cnt_q;
		// completion clear survives a write in the same cycle
		misc_base = misc_q;
		if (mem_cnt_q == 12'h001) misc_base[MISC_MEMTEST_BIT] = 1'b0;
		if (st_cnt_q == 12'h001) misc_base[MISC_SELFTEST_BIT] = 1'b0;
		misc_d = misc_base;
		nd_d = nd_q;
		// timed sleep runs whole half-second steps
		if (slp_q == SLP_TIMED) begin
			if (half_cnt_q == 25'(SLEEP_LSB - 1)) begin
				half_cnt_d = '0;
				naps_d = naps_q - 8'h01;
				if (naps_q == 8'h01) slp_d = SLP_AWAKE;
			end else begin
				half_cnt_d = half_cnt_q + 25'h1;
			end
		end
		if (slp_q == SLP_DORMANT && cs_fall) slp_d = SLP_AWAKE;
		if (frame_evt && fr.wr) begin
			unique case ({fr.addr[6:1], 1'b0})
				ADDR_SMPL: smpl_d = put(smpl_q, fr.addr[0], fr.data, SMPL_MASK);
				ADDR_PIN_IO: begin
					pin_d = put(pin_q, fr.addr[0], fr.data, PIN_IO_MASK);
				end
				ADDR_MISC: begin
					misc_d = put(misc_base, fr.addr[0], fr.data, MISC_MASK);
					if (misc_d[MISC_MEMTEST_BIT] && !misc_base[MISC_MEMTEST_BIT])
						mem_cnt_d = 12'(MEMTEST_CYC);
					if (misc_d[MISC_SELFTEST_BIT] && !misc_base[MISC_SELFTEST_BIT])
						st_cnt_d = 12'(SELFTEST_CYC);
				end
				ADDR_RANGE: begin
					wv = put(range_q, fr.addr[0], fr.data, RANGE_MASK);
					rsel = wv[10:8];
					// only the three legal range codes are accepted
					if (rsel != RANGE_WIDE && rsel != RANGE_MID &&
						rsel != RANGE_NARROW) rsel = range_q[10:8];
					range_d = {5'h00, rsel, 5'h00, wv[2:0]};
					if (wv[2:0] < tap_floor(rsel))
						range_d[2:0] = tap_floor(rsel);
				end
				ADDR_SLEEP: begin
					sleep_d = put(sleep_q, fr.addr[0], fr.data, SLEEP_MASK);
					if (sleep_d[SLEEP_INDEF_BIT]) begin
						slp_d = SLP_DORMANT;
					end else if (!fr.addr[0] && fr.data != 8'h00) begin
						slp_d = SLP_TIMED;
						naps_d = fr.data;
						half_cnt_d = '0;
					end
				end
				default: ;
			endcase
		end
		if (frame_evt && !fr.wr) begin
			unique case ({fr.addr[6:1], 1'b0})
				ADDR_SMPL: rd_word_d = smpl_q;
				ADDR_SLEEP: rd_word_d = sleep_q;
				ADDR_RANGE: rd_word_d = range_q;
				ADDR_PIN_IO: rd_word_d = {4'h0, lvl, 4'h0, pin_q[3:0]};
				ADDR_MISC: rd_word_d = misc_q;
				ADDR_OUT: begin
					rd_word_d = {nd_q, 1'b0, out_q};
					nd_d = 1'b0;
				end
				default: rd_word_d = '0;
			endcase
		end
		if (out_vld) begin
			out_d = filt_out;
			nd_d = 1'b1; // a new sample beats a clearing read
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			smpl_q <= SMPL_RST;
			sleep_q <= SLEEP_RST;
			range_q <= RANGE_RST;
			pin_q <= PIN_IO_RST;
			misc_q <= MISC_RST;
			slp_q <= SLP_AWAKE;
			half_cnt_q <= '0;
			naps_q <= '0;
			mem_cnt_q <= '0;
			st_cnt_q <= '0;
			nd_q <= 1'b0;
			out_q <= '0;
			rd_word_q <= '0;
			done_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
			ln4_prev_q <= 1'b0;
		end else begin
			smpl_q <= smpl_d;
			sleep_q <= sleep_d;
			range_q <= range_d;
			pin_q <= pin_d;
			misc_q <= misc_d;
			slp_q <= slp_d;
			half_cnt_q <= half_cnt_d;
			naps_q <= naps_d;
			mem_cnt_q <= mem_cnt_d;
			st_cnt_q <= st_cnt_d;
			nd_q <= nd_d;
			out_q <= out_d;
			rd_word_q <= rd_word_d;
			done_prev_q <= done_s;
			cs_prev_q <= cs_n_s;
			ln4_prev_q <= io_s[3];
		end
	end

	// sample timing, data-ready pulse, line ownership
	logic [19:0] tb_cnt_q, tb_cnt_d, tb_lim;
	logic [6:0] ns_cnt_q, ns_cnt_d;
	logic tick_q, tick_d, ext_mode;
	logic [12:0] dr_cnt_q, dr_cnt_d;
	logic dr_level;
	logic [3:0] io_out_q, io_out_d, io_oe_q, io_oe_d;
	logic lp_q, lp_d;
	always_comb begin
		tb_lim = smpl_q[SMPL_TB_BIT] ? 20'(TB_SLOW - 1) : 20'(TB_FAST - 1);
		ext_mode = !io_oe_q[3] && smpl_q[7:0] == 8'h00;
		lp_d = smpl_q[7:0] >= LOW_POWER_MIN;
		tb_cnt_d = tb_cnt_q;
		ns_cnt_d = ns_cnt_q;
		tick_d = 1'b0;
		if (slp_q != SLP_AWAKE) begin
			tb_cnt_d = '0;
			ns_cnt_d = '0;
		end else if (ext_mode) begin
			tick_d = ln4_rise;
			tb_cnt_d = '0;
			ns_cnt_d = '0;
		end else if (tb_cnt_q >= tb_lim) begin
			tb_cnt_d = '0;
			if (ns_cnt_q >= smpl_q[6:0]) begin
				ns_cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				ns_cnt_d = ns_cnt_q + 7'h01;
			end
		end else begin
			tb_cnt_d = tb_cnt_q + 20'h00001;
		end
		dr_cnt_d = (dr_cnt_q != 13'h0000) ? dr_cnt_q - 13'h0001 : dr_cnt_q;
		if (out_vld) dr_cnt_d = 13'(DR_PULSE);
		dr_level = (dr_cnt_q != 13'h0000) ~^ misc_q[MISC_DR_POL_BIT];
		for (int i = 0; i < 4; i++) begin
			if (misc_q[MISC_DR_EN_BIT] &&
				i == int'(misc_q[MISC_DR_SEL_BIT])) begin
				io_oe_d[i] = 1'b1;
				io_out_d[i] = dr_level;
			end else if (alarm_drive.own[i]) begin
				io_oe_d[i] = 1'b1;
				io_out_d[i] = alarm_drive.level[i];
			end else begin
				io_oe_d[i] = pin_q[i];
				io_out_d[i] = pin_q[i] & pin_q[8+i];
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tb_cnt_q <= '0;
			ns_cnt_q <= '0;
			tick_q <= 1'b0;
			dr_cnt_q <= '0;
			io_out_q <= '0;
			io_oe_q <= '0;
			lp_q <= 1'b0;
		end else begin
			tb_cnt_q <= tb_cnt_d;
			ns_cnt_q <= ns_cnt_d;
			tick_q <= tick_d;
			dr_cnt_q <= dr_cnt_d;
			io_out_q <= io_out_d;
			io_oe_q <= io_oe_d;
			lp_q <= lp_d;
		end
	end

	// two cascaded averaging stages on each sample
	logic signed [DW-1:0] mid_out;
	logic mid_vld;
	imuio_avg #(.W(DW), .LOGMAX(7)) u_avg1 (
		.clk(mclk),
		.rst(sys_rst),
		.m(range_q[2:0]),
		.in_vld(tick_q),
		.din(sensor_in),
		.dout(mid_out),
		.out_vld(mid_vld)
	);
	imuio_avg #(.W(DW), .LOGMAX(7)) u_avg2 (
		.clk(mclk),
		.rst(sys_rst),
		.m(range_q[2:0]),
		.in_vld(mid_vld),
		.din(mid_out),
		.dout(filt_out),
		.out_vld(out_vld)
	);

	assign io_out = io_out_q;
	assign io_oe = io_oe_q;
	assign sample_tick = tick_q;
	assign low_power = lp_q;
	logic asleep_q;
	always_ff @(posedge mclk) begin
		asleep_q <= !sys_rst && slp_d != SLP_AWAKE;
	end
	assign asleep = asleep_q;
	assign gyro_range = range_q[10:8];
	assign self_test_run = misc_q[MISC_SELFTEST_BIT];
	assign mem_test_run = misc_q[MISC_MEMTEST_BIT];
	assign stim_neg = misc_q[MISC_STIM_NEG_BIT];
	assign stim_pos = misc_q[MISC_STIM_POS_BIT];
	assign bias_comp_en = misc_q[MISC_BIAS_BIT];
	assign origin_align_en = misc_q[MISC_ALIGN_BIT];

	// checks
	localparam int A_ST_MAX = SELFTEST_CYC + 1;
	localparam int A_MT_MAX = MEMTEST_CYC + 1;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [13:0] a_len_q;
	always_ff @(posedge mclk) begin
		// length since the last reload of the pulse counter
		a_len_q <= out_vld ? '0 :
			(dr_cnt_q != 13'h0000) ? a_len_q + 14'h0001 : '0;
	end
	a_dr_pulse_width: assert property ($fell(dr_cnt_q != 13'h0000) && !$past(out_vld)
		|-> a_len_q >= 14'(DR_MIN_CYC) && a_len_q <= 14'(DR_MAX_CYC))
		else $error("data-ready pulse width out of range");
	a_period_reset: assert property ($past(sys_rst) |-> smpl_q == SMPL_RST
		&& misc_q == MISC_RST)
		else $error("reset value wrong");
	a_low_power: assert property (smpl_q[7:0] >= LOW_POWER_MIN |-> ##2 lp_q
		or $changed(smpl_q))
		else $error("low power not entered");
	a_tap_floor: assert property ((gyro_range == RANGE_MID |-> range_q[2:0] >= 3'h2)
		and (gyro_range == RANGE_NARROW |-> range_q[2:0] >= 3'h4))
		else $error("tap field below range floor");
	a_sleep_quiet: assert property (slp_q != SLP_AWAKE |=> !tick_q)
		else $error("sample while asleep");
	a_dormant_wake: assert property (slp_q == SLP_DORMANT && cs_fall
		&& !frame_evt |=> slp_q == SLP_AWAKE)
		else $error("no wake on chip-select");
	a_nd_set: assert property (out_vld |=> nd_q && out_q == $past(filt_out))
		else $error("new data not flagged");
	a_selftest_clear: assert property ($rose(misc_q[MISC_SELFTEST_BIT])
		|-> ##[1:A_ST_MAX] !misc_q[MISC_SELFTEST_BIT])
		else $error("self-test bit stuck");
	a_memtest_clear: assert property ($rose(misc_q[MISC_MEMTEST_BIT])
		|-> ##[1:A_MT_MAX] !misc_q[MISC_MEMTEST_BIT])
		else $error("memory test bit stuck");
	a_dr_owns_line: assert property (misc_q[MISC_DR_EN_BIT] && !alarm_drive.own[0]
		&& !misc_q[MISC_DR_SEL_BIT] |=> io_oe_q[0])
		else $error("data-ready lost line one");
	a_ext_tick: assert property (slp_q == SLP_AWAKE && ext_mode && ln4_rise
		|=> tick_q)
		else $error("external clock edge missed");
	c_dr_pulse: cover property ($fell(dr_cnt_q != 13'h0000));
	c_timed_wake: cover property (slp_q == SLP_TIMED ##1 slp_q == SLP_AWAKE);
	c_dormant_wake: cover property (slp_q == SLP_DORMANT ##1 slp_q == SLP_AWAKE);
	c_ext_tick: cover property (ext_mode && tick_q);
endmodule

// ---- verification/imuio_host.sv ----
// host side serial master model: mode 3, 16-bit frames, msb first
module imuio_host (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// one frame; reply bits caught on rising edges
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		#7;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#62.5 sclk = 1'b0;
			mosi = w[i];
			#62.5 sclk = 1'b1;
			r[i] = miso;
		end
		#62.5 cs_n = 1'b1;
		// released line must not keep its last value
		mosi = ~mosi;
		// idle gap well over 6 mclk, word lands meanwhile
		#500;
	endtask
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the sample and i/o control block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import imuio_pkg::*;
	localparam int FAST = 20;
	localparam int SLOW = 50;
	localparam int SLP = 100;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic [3:0] io_in, io_out, io_oe;
	logic [3:0] ext_q = 4'h0;
	imuio_drive_t alarm_drive = '0;
	logic signed [13:0] sensor_in = '0;
	logic sample_tick, low_power, asleep, self_test_run, mem_test_run;
	logic stim_neg, stim_pos, bias_comp_en, origin_align_en;
	logic [2:0] gyro_range;
	logic [15:0] mdl [int];
	int seed = 62661;
	int n_mismatch = 0;
	int comparisons = 0;
	always #12.5 mclk = ~mclk;
	assign io_in = (io_oe & io_out) | (~io_oe & ext_q);
	always @(negedge mclk) sensor_in <= 14'($random(seed));
	imuio_host u_imuio_host (.sclk(spi_sclk), .cs_n(spi_cs_n),
		.mosi(spi_mosi), .miso(spi_miso));
	imuio_top #(.TB_FAST(FAST), .TB_SLOW(SLOW), .DR_PULSE(DR_PULSE_CYC),
		.SLEEP_LSB(SLP)) u_imuio_top (.mclk(mclk), .sys_rst(sys_rst),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .alarm_drive(alarm_drive),
		.sensor_in(sensor_in), .sample_tick(sample_tick),
		.low_power(low_power), .asleep(asleep), .gyro_range(gyro_range),
		.self_test_run(self_test_run), .mem_test_run(mem_test_run),
		.stim_neg(stim_neg), .stim_pos(stim_pos),
		.bias_comp_en(bias_comp_en), .origin_align_en(origin_align_en));
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// byte write, model follows range/tap coupling and writable bits
	task automatic wr(logic [6:0] a, logic [7:0] d);
		logic [15:0] r;
		logic [15:0] v;
		int k;
		u_imuio_host.xfer({1'b1, a, d}, r);
		k = int'(a & 7'h7e);
		v = mdl.exists(k) ? mdl[k] : 16'h0000;
		if (a[0]) v[15:8] = d;
		else v[7:0] = d;
		case (k)
			'h36: v &= 16'h00ff;
			'h32: v &= PIN_IO_MASK;
			'h34: v &= MISC_MASK;
			'h38: begin
				v &= RANGE_MASK;
				if (!(v[10:8] inside {3'h4, 3'h2, 3'h1})) v[10:8] = mdl[k][10:8];
				if (v[10:8] == 3'h2 && v[2:0] < 3'h2) v[2:0] = 3'h2;
				if (v[10:8] == 3'h1 && v[2:0] < 3'h4) v[2:0] = 3'h4;
			end
			default: ;
		endcase
		mdl[k] = v;
	endtask
	// read answer arrives on the following frame
	task automatic rd(logic [6:0] a, output logic [15:0] r);
		u_imuio_host.xfer({1'b0, a, 8'h00}, r);
		u_imuio_host.xfer(16'h0000, r);
	endtask
	task automatic rchk(string nm, logic [6:0] a);
		logic [15:0] r;
		rd(a, r);
		chk(nm, r, mdl[int'(a)]);
	endtask
	task automatic gap(output int n);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (sample_tick !== 1'b1 && n < 9000);
	endtask
	task automatic dr_width(logic act);
		int n;
		n = 0;
		while (io_out[0] === act && n < 9000) begin
			@(negedge mclk);
			n++;
		end
		while (io_out[0] !== act && n < 18000) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		while (io_out[0] === act && n < 9000) begin
			@(negedge mclk);
			n++;
		end
		chk("dr_width", 16'(n >= DR_MIN_CYC && n <= DR_MAX_CYC), 1);
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		logic [15:0] r;
		logic [7:0] v;
		int n;
		mdl['h36] = 16'h0001;
		mdl['h38] = 16'h0402;
		mdl['h32] = 16'h0000;
		mdl['h34] = 16'h0006;
		repeat (2) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
		chk("dr_idle", {io_oe[0], io_out[0]}, 2'b10);
		chk("range_out", gyro_range, 3'h4);
		foreach (mdl[k]) rchk("reset_val", 7'(k));
		// taps written before range
		wr('h38, 8'h00);
		rchk("taps_wide", 'h38);
		for (int i = 0; i < 4; i++) begin
			wr('h39, 8'(i == 3 ? 3 : 1 << (1 - i % 2)));
			rchk("range_taps", 'h38);
			chk("range_out", gyro_range, mdl['h38][10:8]);
		end
		wr('h39, 8'h04);
		wr('h38, 8'h05);
		rchk("range_taps", 'h38);
		for (int i = 0; i < 4; i++) begin
			// low byte zero would select the external clock
			v = {1'b0, 7'($random(seed) & 7) + 7'h01};
			if (i == 1) v = 8'h09;
			if (i == 2) v = 8'h0a;
			if (i == 3) v[7] = 1'b1;
			wr('h36, v);
			gap(n);
			gap(n);
			chk("period", 16'(n), 16'((v[7] ? SLOW : FAST) * (v[6:0] + 1)));
			chk("low_power", low_power, 16'(v >= 8'h0a));
		end
		wr('h36, 8'hff);
		dr_width(1'b1);
		wr('h34, 8'h04);
		dr_width(1'b0);
		for (int i = 0; i < 2; i++) begin
			wr('h35, i ? 8'h04 : 8'h08);
			chk("test_run", {mem_test_run, self_test_run}, i ? 2'b01 : 2'b10);
			repeat (1000) @(negedge mclk);
			chk("test_run", {mem_test_run, self_test_run}, 2'b00);
			mdl['h34][11:10] = 2'b00;
			rchk("misc", 'h34);
		end
		wr('h35, 8'h03);
		wr('h34, 8'hc0);
		chk("misc_bits", {stim_neg, stim_pos, bias_comp_en, origin_align_en},
			4'hf);
		rchk("misc", 'h34);
		wr('h35, 8'h00);
		wr('h33, 8'h08);
		wr('h32, 8'h0c);
		rchk("pin", 'h32);
		chk("pin_oe", io_oe, 4'b1100);
		chk("pin_out", io_out[3:2], 2'b10);
		@(negedge mclk);
		alarm_drive = '{own: 4'b0011, level: 4'b0001};
		wr('h34, 8'h05);
		chk("own", {io_oe, io_out[3:2], io_out[0]}, 7'b1111101);
		@(negedge mclk);
		alarm_drive = '0;
		wr('h32, 8'h00);
		wr('h36, 8'h00);
		repeat (10) @(negedge mclk);
		ext_q[3] = 1'b1;
		gap(n);
		chk("ext_tick", 16'(n <= 8), 1);
		rd('h04, r);
		chk("new_data", r[15], 1'b1);
		rd('h04, r);
		chk("new_data", r[15], 1'b0);
		fork
			wr('h3a, 8'h02);
			begin
				n = 0;
				while (asleep !== 1'b1 && n < 200) begin
					@(negedge mclk);
					n++;
				end
				n = 0;
				while (asleep === 1'b1 && n < 1000) begin
					@(negedge mclk);
					n++;
				end
			end
		join
		chk("timed_sleep", 16'(n >= 2 * SLP - 2 && n <= 2 * SLP + 2), 1);
		rchk("range", 'h38);
		wr('h3b, 8'h01);
		repeat (100) @(negedge mclk);
		chk("asleep", asleep, 1'b1);
		rchk("range", 'h38);
		chk("asleep", asleep, 1'b0);
		rchk("period", 'h36);
		finish_test();
	end
endmodule
